// File: shared/sesp_pkg.sv
// constants and types shared by the serial eeprom status and protection core
package sesp_pkg;

   // command codes, shifted in most significant bit first
   localparam logic [7:0] CMD_WRITE_ENABLE  = 8'h06;
   localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] CMD_STATUS_READ   = 8'h05;
   localparam logic [7:0] CMD_STATUS_WRITE  = 8'h01;
   localparam logic [7:0] CMD_ARRAY_READ    = 8'h03;
   localparam logic [7:0] CMD_ARRAY_WRITE   = 8'h02;

   // array addressing: only the low address bits are significant
   localparam int          ADDR_W         = 18;
   localparam logic [2:0]  ADDR_LAST_BYTE = 3'h3;   // byte 0 is the command
   localparam logic [2:0]  BYTE_CNT_MAX   = 3'h7;   // byte counter saturates here
   localparam logic [2:0]  BYTE_LAST_BIT  = 3'h7;   // bit index of a byte's last bit
   localparam logic [2:0]  BYTE_FIRST_BIT = 3'h0;

   // status byte layout
   localparam int          ST_BUSY_BIT  = 0;
   localparam int          ST_WEL_BIT   = 1;
   localparam int          ST_BP_LO_BIT = 2;
   localparam int          ST_BP_HI_BIT = 3;
   localparam int          ST_LOCK_BIT  = 7;
   localparam logic [2:0]  ST_ZERO_BITS = 3'h0;     // bits 6..4 always read zero

   // delivery values of the nonvolatile bits
   localparam logic [1:0]  BP_RESET   = 2'h0;
   localparam logic        LOCK_RESET = 1'b0;

   // block protect encodings and the base of each protected region
   localparam logic [1:0]         BP_NONE     = 2'h0;
   localparam logic [1:0]         BP_QUARTER  = 2'h1;
   localparam logic [1:0]         BP_HALF     = 2'h2;
   localparam logic [1:0]         BP_ALL      = 2'h3;
   localparam logic [ADDR_W-1:0]  QUARTER_BASE = 18'h30000;
   localparam logic [ADDR_W-1:0]  HALF_BASE    = 18'h20000;

   // self-timed write cycle length
   localparam int unsigned REF_CLK_PERIOD_NS        = 10;
   localparam int unsigned SELF_TIMED_WRITE_TIME_NS = 5000000;
   localparam int unsigned WRITE_CYCLES_DEF =
      (SELF_TIMED_WRITE_TIME_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;

   // link-side command sequencer, gray along cmd->addr->read, cmd->data and cmd->wait
   typedef enum logic [2:0] {
      ST_CMD    = 3'h0,
      ST_ADDR   = 3'h1,
      ST_READ   = 3'h3,
      ST_DATA   = 3'h2,
      ST_STATUS = 3'h6,
      ST_WAIT   = 3'h4
   } sesp_state_e;

   // command left pending for execution when chip select rises
   typedef enum logic [2:0] {
      PEND_NONE  = 3'h0,
      PEND_WRITE_ENABLE_CMD  = 3'h1,
      PEND_WRITE_DISABLE_CMD  = 3'h2,
      PEND_STATUS_WRITE_CMD  = 3'h3,
      PEND_WRITE = 3'h4
   } sesp_pend_e;

endpackage

// File: src/sesp_core.sv
// serial eeprom command core: enable latch, status register, protection, array read
//
// Contract
// - write enable needed before every write
// - enable/disable wait for deselect before acting
// - latch cleared at reset, disable, write completion
// - status read anytime, byte repeats while selected
// - busy flag high only during write cycle
// - writes refused while enable latch clear
// - block protect set only by status write
// - locked and pin low refuses status writes
// - status write needs exact byte boundary
// - status write starts timed busy cycle
// - new protect bits apply after cycle ends
// - other status bits unchanged, 6..4 zero
// - lock clear: status writes ignore pin
// - lock set, pin high: writes accepted
// - hardware protection left only via pin
// - read loads address, bytes msb first
// - read address increments, wraps to zero
// - deselect ends read, output floats
// - array read refused during write cycle
// - enable, disable, status read codes; others wait
// - msb first; status write, read codes
// - block protect region encoding
// - three address bytes, eighteen significant bits
`timescale 1ns/1ps

module sesp_core #(
   parameter int unsigned WRITE_CYCLES = sesp_pkg::WRITE_CYCLES_DEF
) (
   // system clock and reset
   input  wire logic                        ref_clk,
   input  wire logic                        rst_n,
   // serial link from the host
   input  wire logic                        spi_sclk,
   input  wire logic                        spi_cs_n,
   input  wire logic                        spi_mosi,
   output logic                             spi_miso_o,
   output logic                             spi_miso_oe,
   // write protect pin
   input  wire logic                        wp_n,
   // array read port, clocked by the serial clock
   output logic [sesp_pkg::ADDR_W-1:0]      array_rd_addr,
   input  wire logic [7:0]                  array_rd_data,
   // array write request, system clock
   output logic                             arr_wr_stb,
   output logic [sesp_pkg::ADDR_W-1:0]      arr_wr_addr,
   output logic [7:0]                       arr_wr_data,
   // status byte as seen by software
   output logic [7:0]                       status_out
);

   // ------------------------------------------------------------------
   // link domain (serial clock)
   // ------------------------------------------------------------------

   logic [2:0]                   bit_idx_ff;      // bit position within byte
   logic [2:0]                   byte_cnt_ff;     // bytes completed this frame
   logic [6:0]                   shift_ff;        // incoming bits of current byte
   sesp_pkg::sesp_state_e        state_ff;        // command sequencer
   sesp_pkg::sesp_state_e        nxt_state;
   logic                         cmd_is_write_ff; // array write vs status write
   logic [sesp_pkg::ADDR_W-1:0]  addr_ff;         // internal address register
   sesp_pkg::sesp_pend_e         pend_kind_ff;    // command complete at a boundary
   logic [7:0]                   pend_data_ff;    // data byte of that command
   logic [7:0]                   st_s1_ff;        // status sync, first stage
   logic [7:0]                   st_s2_ff;        // status sync, second stage
   logic [7:0]                   out_sh_ff;       // outgoing byte
   logic                         q_ff;            // serial output bit
   logic                         oe_ff;           // serial output enable
   logic                         byte_done;       // this edge completes a byte
   logic [7:0]                   byte_in;         // byte completed on this edge
   logic                         busy_lnk;        // busy flag as seen by the link

   assign byte_done = (bit_idx_ff == sesp_pkg::BYTE_LAST_BIT);
   assign byte_in   = {shift_ff, spi_mosi};
   assign busy_lnk  = st_s2_ff[sesp_pkg::ST_BUSY_BIT];

   // bit and byte framing; deselect restarts the frame
   // sample on rising edge
   always_ff @(posedge spi_sclk or posedge spi_cs_n or negedge rst_n) begin
      if (!rst_n) begin
         bit_idx_ff  <= sesp_pkg::BYTE_FIRST_BIT;
         byte_cnt_ff <= 3'h0;
         shift_ff    <= 7'h00;
      end else if (spi_cs_n) begin
         bit_idx_ff  <= sesp_pkg::BYTE_FIRST_BIT;
         byte_cnt_ff <= 3'h0;
         shift_ff    <= 7'h00;
      end else begin
         bit_idx_ff <= 3'(bit_idx_ff + 3'h1);
         shift_ff   <= byte_in[6:0];
         // saturate so long reads never alias back onto the address bytes
         if (byte_done && byte_cnt_ff != sesp_pkg::BYTE_CNT_MAX) begin
            byte_cnt_ff <= 3'(byte_cnt_ff + 3'h1);
         end
      end
   end

   // next state of the command sequencer
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         sesp_pkg::ST_CMD: begin
            if (byte_done) begin
               case (byte_in)
                  // enable and disable then wait for deselect
                  sesp_pkg::CMD_WRITE_ENABLE,
                  sesp_pkg::CMD_WRITE_DISABLE: begin
                     nxt_state = sesp_pkg::ST_WAIT;
                  end
                  sesp_pkg::CMD_STATUS_READ: begin
                     nxt_state = sesp_pkg::ST_STATUS;
                  end
                  sesp_pkg::CMD_STATUS_WRITE: begin
                     nxt_state = sesp_pkg::ST_DATA;
                  end
                  sesp_pkg::CMD_ARRAY_READ: begin
                     nxt_state = busy_lnk ? sesp_pkg::ST_WAIT : sesp_pkg::ST_ADDR;
                  end
                  sesp_pkg::CMD_ARRAY_WRITE: begin
                     nxt_state = sesp_pkg::ST_ADDR;
                  end
                  default: begin
                     nxt_state = sesp_pkg::ST_WAIT;
                  end
               endcase
            end
         end
         sesp_pkg::ST_ADDR: begin
            // three address bytes follow the command
            if (byte_done && byte_cnt_ff == sesp_pkg::ADDR_LAST_BYTE) begin
               nxt_state = cmd_is_write_ff ? sesp_pkg::ST_DATA : sesp_pkg::ST_READ;
            end
         end
         sesp_pkg::ST_DATA: begin
            // status write takes exactly one data byte, array write any number
            if (byte_done && !cmd_is_write_ff) begin
               nxt_state = sesp_pkg::ST_WAIT;
            end
         end
         // read, status read and wait hold until deselect
         sesp_pkg::ST_READ,
         sesp_pkg::ST_STATUS,
         sesp_pkg::ST_WAIT: begin
            nxt_state = state_ff;
         end
         default: begin
            nxt_state = sesp_pkg::ST_WAIT;
         end
      endcase
   end

   // sequencer register, cleared by deselect
   // deselect ends any command cleanly
   always_ff @(posedge spi_sclk or posedge spi_cs_n or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= sesp_pkg::ST_CMD;
      end else if (spi_cs_n) begin
         state_ff <= sesp_pkg::ST_CMD;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // command kind and address register; kept over deselect so the
   // system side can read the write address once the clock has stopped
   always_ff @(posedge spi_sclk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_is_write_ff <= 1'b0;
         addr_ff         <= '0;
      end else begin
         if (state_ff == sesp_pkg::ST_CMD && byte_done) begin
            cmd_is_write_ff <= (byte_in == sesp_pkg::CMD_ARRAY_WRITE);
         end
         if (state_ff == sesp_pkg::ST_ADDR) begin
            // upper address bits shift out of the top and are lost
            addr_ff <= {addr_ff[sesp_pkg::ADDR_W-2:0], spi_mosi};
         end else if (state_ff == sesp_pkg::ST_READ && byte_done) begin
            // increment per byte, natural wrap to zero
            addr_ff <= sesp_pkg::ADDR_W'(addr_ff + 1'b1);
         end
      end
   end

   // pending command: valid only if the last edge closed a command byte;
   // any further edge cancels it, so a late deselect discards the command
   always_ff @(posedge spi_sclk or negedge rst_n) begin
      if (!rst_n) begin
         pend_kind_ff <= sesp_pkg::PEND_NONE;
         pend_data_ff <= 8'h00;
      end else if (state_ff == sesp_pkg::ST_CMD && byte_done &&
                   byte_in == sesp_pkg::CMD_WRITE_ENABLE) begin
         pend_kind_ff <= sesp_pkg::PEND_WRITE_ENABLE_CMD;
      end else if (state_ff == sesp_pkg::ST_CMD && byte_done &&
                   byte_in == sesp_pkg::CMD_WRITE_DISABLE) begin
         pend_kind_ff <= sesp_pkg::PEND_WRITE_DISABLE_CMD;
      end else if (state_ff == sesp_pkg::ST_DATA && byte_done) begin
         pend_kind_ff <= cmd_is_write_ff ? sesp_pkg::PEND_WRITE : sesp_pkg::PEND_STATUS_WRITE_CMD;
         pend_data_ff <= byte_in;
      end else begin
         pend_kind_ff <= sesp_pkg::PEND_NONE;
      end
   end

   // status byte into the link domain; the command byte gives the
   // synchroniser eight edges to settle before the first status bit
   always_ff @(posedge spi_sclk or negedge rst_n) begin
      if (!rst_n) begin
         st_s1_ff <= 8'h00;
         st_s2_ff <= 8'h00;
      end else begin
         st_s1_ff <= status_out;
         st_s2_ff <= st_s1_ff;
      end
   end

   // serial output; floats whenever deselected
   // drive on falling edge
   always_ff @(negedge spi_sclk or posedge spi_cs_n or negedge rst_n) begin
      if (!rst_n) begin
         q_ff      <= 1'b0;
         oe_ff     <= 1'b0;
         out_sh_ff <= 8'h00;
      end else if (spi_cs_n) begin
         q_ff      <= 1'b0;
         oe_ff     <= 1'b0;
         out_sh_ff <= 8'h00;
      end else begin
         oe_ff <= (state_ff == sesp_pkg::ST_READ) || (state_ff == sesp_pkg::ST_STATUS);
         if (state_ff == sesp_pkg::ST_STATUS && bit_idx_ff == sesp_pkg::BYTE_FIRST_BIT) begin
            q_ff      <= st_s2_ff[7];
            out_sh_ff <= st_s2_ff;
         end else if (state_ff == sesp_pkg::ST_READ &&
                      bit_idx_ff == sesp_pkg::BYTE_FIRST_BIT) begin
            q_ff      <= array_rd_data[7];
            out_sh_ff <= array_rd_data;
         end else begin
            q_ff      <= out_sh_ff[6];
            out_sh_ff <= {out_sh_ff[6:0], 1'b0};
         end
      end
   end

   assign spi_miso_o    = q_ff;
   assign spi_miso_oe   = oe_ff;
   assign array_rd_addr = addr_ff;

   // ------------------------------------------------------------------
   // system domain (ref_clk)
   // ------------------------------------------------------------------

   logic                         cs_s1_ff;        // chip select sync
   logic                         cs_s2_ff;
   logic                         cs_d_ff;         // delayed for edge detect
   logic                         wp_s1_ff;        // protect pin sync
   logic                         wp_s2_ff;
   logic                         wel_ff;          // write enable latch
   logic                         busy_ff;         // self-timed cycle running
   logic                         op_status_ff;    // running cycle is a status write
   logic [31:0]                  wcnt_ff;         // cycle timer
   logic [7:0]                   staged_ff;       // status byte awaiting commit
   logic [1:0]                   bp_ff;           // block protect bits
   logic                         lock_ff;         // status lock bit
   logic                         wr_stb_ff;
   logic [sesp_pkg::ADDR_W-1:0]  wr_addr_ff;
   logic [7:0]                   wr_data_ff;
   logic [7:0]                   status_ff;
   logic                         cs_rise;
   logic                         hw_prot;
   logic                         region_locked;
   logic                         status_write_cmd_go;
   logic                         write_go;
   logic                         cycle_done;

   // chip select and protect pin into the system domain
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cs_s1_ff <= 1'b1;
         cs_s2_ff <= 1'b1;
         cs_d_ff  <= 1'b1;
         wp_s1_ff <= 1'b1;
         wp_s2_ff <= 1'b1;
      end else begin
         cs_s1_ff <= spi_cs_n;
         cs_s2_ff <= cs_s1_ff;
         cs_d_ff  <= cs_s2_ff;
         wp_s1_ff <= wp_n;
         wp_s2_ff <= wp_s1_ff;
      end
   end

   // pending command and address are stable here: the serial clock
   // has stopped since the deselect that this edge reports
   assign cs_rise = cs_s2_ff && !cs_d_ff;

   // follows pin in either order, left only by pin high
   assign hw_prot = lock_ff && !wp_s2_ff;

   always_comb begin
      case (bp_ff)
         sesp_pkg::BP_NONE:    region_locked = 1'b0;
         sesp_pkg::BP_QUARTER: region_locked = (addr_ff >= sesp_pkg::QUARTER_BASE);
         sesp_pkg::BP_HALF:    region_locked = (addr_ff >= sesp_pkg::HALF_BASE);
         sesp_pkg::BP_ALL:     region_locked = 1'b1;
         default:              region_locked = 1'b1;
      endcase
   end

   // with lock clear the pin is ignored
   // lock set, pin high behaves the same
   assign status_write_cmd_go  = cs_rise && pend_kind_ff == sesp_pkg::PEND_STATUS_WRITE_CMD &&
                     wel_ff && !busy_ff && !hw_prot;
   assign write_go = cs_rise && pend_kind_ff == sesp_pkg::PEND_WRITE &&
                     wel_ff && !busy_ff && !region_locked;
   assign cycle_done = busy_ff && (wcnt_ff == 32'(WRITE_CYCLES - 1));

   // write enable latch
   // only the enable command sets it
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wel_ff <= 1'b0;
      end else if (cycle_done) begin
         wel_ff <= 1'b0;
      end else if (cs_rise && pend_kind_ff == sesp_pkg::PEND_WRITE_ENABLE_CMD) begin
         wel_ff <= 1'b1;
      end else if (cs_rise && pend_kind_ff == sesp_pkg::PEND_WRITE_DISABLE_CMD) begin
         wel_ff <= 1'b0;
      end
   end

   // self-timed write cycle
   // deselect at boundary starts the timed cycle
   // busy exactly while the timer runs
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_ff      <= 1'b0;
         op_status_ff <= 1'b0;
         wcnt_ff      <= 32'h0000_0000;
         staged_ff    <= 8'h00;
      end else if (status_write_cmd_go || write_go) begin
         busy_ff      <= 1'b1;
         op_status_ff <= status_write_cmd_go;
         wcnt_ff      <= 32'h0000_0000;
         staged_ff    <= pend_data_ff;
      end else if (cycle_done) begin
         busy_ff <= 1'b0;
         wcnt_ff <= 32'h0000_0000;
      end else if (busy_ff) begin
         wcnt_ff <= 32'(wcnt_ff + 32'h0000_0001);
      end
   end

   // nonvolatile protect bits, written only by a finished status write
   // commit at end of cycle
   // only lock and protect bits taken
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bp_ff   <= sesp_pkg::BP_RESET;
         lock_ff <= sesp_pkg::LOCK_RESET;
      end else if (cycle_done && op_status_ff) begin
         bp_ff   <= {staged_ff[sesp_pkg::ST_BP_HI_BIT], staged_ff[sesp_pkg::ST_BP_LO_BIT]};
         lock_ff <= staged_ff[sesp_pkg::ST_LOCK_BIT];
      end
   end

   // array write request towards the storage, one pulse per accepted write
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_stb_ff  <= 1'b0;
         wr_addr_ff <= '0;
         wr_data_ff <= 8'h00;
      end else begin
         wr_stb_ff <= write_go;
         if (write_go) begin
            wr_addr_ff <= addr_ff;
            wr_data_ff <= pend_data_ff;
         end
      end
   end

   // registered status byte
   // busy, latch, protect, lock positions
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_ff <= 8'h00;
      end else begin
         status_ff <= {lock_ff, sesp_pkg::ST_ZERO_BITS, bp_ff[1], bp_ff[0], wel_ff, busy_ff};
      end
   end

   assign arr_wr_stb  = wr_stb_ff;
   assign arr_wr_addr = wr_addr_ff;
   assign arr_wr_data = wr_data_ff;
   assign status_out  = status_ff;

endmodule

// File: dv/sesp_core_properties.sv
// concurrent checks on the status and protection core ports
`timescale 1ns/1ps
module sesp_core_properties #(
   parameter int unsigned WRITE_CYCLES = sesp_pkg::WRITE_CYCLES_DEF
) (
   // clock and reset
   input wire logic                         ref_clk,
   input wire logic                         rst_n,
   // link side
   input wire logic                         spi_sclk,
   input wire logic                         spi_cs_n,
   input wire logic                         spi_miso_oe,
   // device state
   input wire logic [sesp_pkg::ADDR_W-1:0]  array_rd_addr,
   input wire logic [7:0]                   status_out
);
   logic [31:0] busy_cnt_ff;   // cycles the busy flag has stood high
   logic [31:0] nxt_busy_cnt;
   wire  [2:0]  prot = {status_out[7], status_out[3:2]};   // lock and block protect

   // busy length counter, cleared whenever busy is low
   assign nxt_busy_cnt = status_out[0] ? busy_cnt_ff + 32'h1 : 32'h0;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_cnt_ff <= 32'h0;
      end else begin
         busy_cnt_ff <= nxt_busy_cnt;
      end
   end

   // end of a self-timed cycle
   sequence s_cycle_end;
      $fell(status_out[0]);
   endsequence

   AST_OE_DESELECT: assert property (@(posedge ref_clk) disable iff (!rst_n)
      spi_cs_n |-> !spi_miso_oe) else $error("output enabled while deselected");
   AST_ZERO_BITS: assert property (@(posedge ref_clk) disable iff (!rst_n)
      1'b1 |-> status_out[6:4] == 3'h0) else $error("status bits 6..4 not zero");
   AST_WEL_AFTER_DESELECT: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(status_out[1]) |-> $past(spi_cs_n, 2)) else $error("latch set while selected");
   AST_END_CLEARS_WEL: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_cycle_end |=> !status_out[1]) else $error("latch kept after write cycle");
   AST_PROT_HELD_BUSY: assert property (@(posedge ref_clk) disable iff (!rst_n)
      status_out[0] && $past(status_out[0]) |-> $stable(prot)) else $error("protect changed in cycle");
   AST_PROT_AT_END: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $changed(prot) |-> !status_out[0] && $past(status_out[0], 2)) else $error("protect changed outside write");
   AST_BUSY_LEN: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_cycle_end |-> busy_cnt_ff >= WRITE_CYCLES - 1 && busy_cnt_ff <= WRITE_CYCLES + 1)
      else $error("write cycle length wrong");
   AST_BUSY_MAX: assert property (@(posedge ref_clk) disable iff (!rst_n)
      1'b1 |-> busy_cnt_ff <= WRITE_CYCLES + 1) else $error("busy stuck high");
   AST_ADDR_STEP: assert property (@(posedge spi_sclk) disable iff (!rst_n)
      $past(spi_miso_oe) && !spi_cs_n && array_rd_addr != $past(array_rd_addr)
      |-> array_rd_addr == $past(array_rd_addr) + 18'h1) else $error("read address not stepped by one");
endmodule

bind sesp_core sesp_core_properties #(.WRITE_CYCLES(WRITE_CYCLES)) sesp_core_properties_inst (
   .ref_clk(ref_clk), .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
   .spi_miso_oe(spi_miso_oe), .array_rd_addr(array_rd_addr), .status_out(status_out));

// File: dv/sesp_spi_host.sv
// behavioural serial host: one frame per call, clock idles low
`timescale 1ns/1ps
module sesp_spi_host (
   // link driven by the host
   output logic      spi_sclk,
   output logic      spi_cs_n,
   output logic      spi_mosi,
   // link driven by the device
   input wire logic  spi_miso_o,
   input wire logic  spi_miso_oe
);
   logic seen_oe;   // device drove the line during the last frame

   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
      seen_oe = 1'b0;
   end

   // msb first, data set while clock low, sampled on rise
   task automatic frame(input logic [63:0] tx, input int nbits, output logic [63:0] rx);
      rx = 64'h0;
      seen_oe = 1'b0;
      spi_cs_n = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         spi_mosi = tx[63-i];
         #24 spi_sclk = 1'b1;
         // a released line reads as the inverse of spi_miso_o
         rx[63-i] = spi_miso_oe ? spi_miso_o : ~spi_miso_o;
         seen_oe = seen_oe | spi_miso_oe;
         #24 spi_sclk = 1'b0;
      end
      // deselect before any further rise; data line no longer meaningful
      #12 spi_cs_n = 1'b1;
      spi_mosi = ~spi_mosi;
      #100;
   endtask
endmodule

// File: dv/sesp_core_tb_top.sv
// self-checking bench for the serial eeprom status and protection core
`timescale 1ns/1ps
module sesp_core_tb_top;
   localparam int unsigned WCYC = 200;   // short self-timed cycle keeps the run brief
   logic        ref_clk;
   logic        rst_n;
   logic        wp_n;
   logic        spi_sclk;
   logic        spi_cs_n;
   logic        spi_mosi;
   logic        spi_miso_o;
   logic        spi_miso_oe;
   logic [17:0] array_rd_addr;
   logic [7:0]  array_rd_data;
   logic [7:0]  status_out;
   logic        arr_wr_stb;
   logic [17:0] arr_wr_addr;
   logic [7:0]  arr_wr_data;
   logic [25:0] wr_seen;        // address and data of the last accepted write
   int          n_writes = 0;   // accepted array writes seen
   int          num_errors = 0;
   int          n_checks = 0;

   // array content: offset low byte, distinct across the wrap point
   assign array_rd_data = array_rd_addr[7:0] + 8'h5a;

   sesp_core #(.WRITE_CYCLES(WCYC)) sesp_core_inst (
      .ref_clk(ref_clk), .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
      .spi_mosi(spi_mosi), .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe), .wp_n(wp_n),
      .array_rd_addr(array_rd_addr), .array_rd_data(array_rd_data), .arr_wr_stb(arr_wr_stb),
      .arr_wr_addr(arr_wr_addr), .arr_wr_data(arr_wr_data), .status_out(status_out));
   sesp_spi_host sesp_spi_host_inst (
      .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
      .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe));

   // system clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // array writes, captured at the edge that ends the one-cycle strobe
   always @(posedge ref_clk) begin
      if (arr_wr_stb === 1'b1) begin
         n_writes <= n_writes + 1;
         wr_seen  <= {arr_wr_addr, arr_wr_data};
      end
   end

   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // one frame: command byte, one further byte, bit count
   task automatic send(input logic [7:0] cmd, input logic [7:0] dat, input int nb);
      logic [63:0] rx;
      sesp_spi_host_inst.frame({cmd, dat, 48'h0}, nb, rx);
   endtask

   // status read, two repeated bytes
   task automatic rd_status(input logic [7:0] exp);
      logic [63:0] rx;
      sesp_spi_host_inst.frame({sesp_pkg::CMD_STATUS_READ, 56'h0}, 24, rx);
      check("status_first", rx[55:48], exp);
      check("status_again", rx[47:40], exp);
   endtask

   // poll busy to its end under a bound
   task automatic wait_idle();
      int n;
      n = 0;
      while (status_out[0] !== 1'b0 && n < 1000) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      check("busy_ends", n < 1000, 1);
   endtask

   initial begin
      logic [63:0] rx;
      rst_n = 1'b0;
      wp_n = 1'b1;
      repeat (10) @(posedge ref_clk);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge ref_clk);
      rd_status(8'h00);
      send(sesp_pkg::CMD_WRITE_ENABLE, 8'h00, 8);
      rd_status(8'h02);
      send(sesp_pkg::CMD_WRITE_DISABLE, 8'h00, 8);
      rd_status(8'h00);
      send(sesp_pkg::CMD_STATUS_WRITE, 8'hff, 16);
      rd_status(8'h00);
      send(sesp_pkg::CMD_WRITE_ENABLE, 8'h00, 8);
      send(sesp_pkg::CMD_STATUS_WRITE, 8'hff, 16);
      rd_status(8'h03);
      wait_idle();
      rd_status(8'h8c);
      // lock set, then pin low: status now frozen
      @(posedge ref_clk);
      #1 wp_n = 1'b0;
      send(sesp_pkg::CMD_WRITE_ENABLE, 8'h00, 8);
      send(sesp_pkg::CMD_STATUS_WRITE, 8'h00, 16);
      check("busy_hw_locked", status_out[0], 0);
      rd_status(8'h8e);
      @(posedge ref_clk);
      #1 wp_n = 1'b1;
      send(sesp_pkg::CMD_STATUS_WRITE, 8'h00, 17);
      rd_status(8'h8e);
      send(sesp_pkg::CMD_STATUS_WRITE, 8'h00, 16);
      wait_idle();
      rd_status(8'h00);
      sesp_spi_host_inst.frame({8'hab, 56'h0}, 24, rx);
      check("unknown_code_quiet", sesp_spi_host_inst.seen_oe, 0);
      // read across the top of the array, dropped mid-byte
      sesp_spi_host_inst.frame({sesp_pkg::CMD_ARRAY_READ, 24'hfffffe, 32'h0}, 52, rx);
      check("read_top", rx[31:24], 8'h58);
      check("read_wrap", {rx[23:16], rx[15:12]}, 12'h595);
      check("oe_after_abort", spi_miso_oe, 0);
      send(sesp_pkg::CMD_WRITE_ENABLE, 8'h00, 8);
      send(sesp_pkg::CMD_STATUS_WRITE, 8'h00, 16);
      sesp_spi_host_inst.frame({sesp_pkg::CMD_ARRAY_READ, 56'h0}, 40, rx);
      check("read_while_busy", sesp_spi_host_inst.seen_oe, 0);
      wait_idle();
      rd_status(8'h00);
      // single-byte array write, then a write into the protected upper half
      send(sesp_pkg::CMD_WRITE_ENABLE, 8'h00, 8);
      sesp_spi_host_inst.frame({sesp_pkg::CMD_ARRAY_WRITE, 24'h012345, 8'ha5, 24'h0}, 40, rx);
      wait_idle();
      check("write_seen", {n_writes[1:0], wr_seen}, {2'h1, 18'h12345, 8'ha5});
      send(sesp_pkg::CMD_WRITE_ENABLE, 8'h00, 8);
      send(sesp_pkg::CMD_STATUS_WRITE, 8'h08, 16);
      wait_idle();
      send(sesp_pkg::CMD_WRITE_ENABLE, 8'h00, 8);
      sesp_spi_host_inst.frame({sesp_pkg::CMD_ARRAY_WRITE, 24'h020000, 8'h3c, 24'h0}, 40, rx);
      rd_status(8'h0a);
      check("protected_write", n_writes, 1);
      close_out();
   end

   // watchdog well beyond the expected run length
   initial begin
      #300000;
      num_errors++;
      close_out();
   end
endmodule
